// ===== shared/asb_pkg.sv
// Package holding pin widths, timing counts and command types for the static memory host.
package asb_pkg;

  // Memory organisation.
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned LANE_W = 8;
  localparam int unsigned LANES  = 2;

  // Clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 20;

  // Pin timing in nanoseconds.
  localparam int unsigned READ_CYCLE_NS                  = 55;
  localparam int unsigned WRITE_PULSE_NS                 = 35;
  localparam int unsigned STROBE_TO_OUTPUT_OFF_DELAY_NS  = 18;
  localparam int unsigned DATA_SETUP_BEFORE_WRITE_END_NS = 25;
  localparam int unsigned OUTPUT_OFF_NS                  = 18;

  // Cycle counts; least times round up.
  localparam int unsigned READ_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_A  = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_B  = (STROBE_TO_OUTPUT_OFF_DELAY_NS
                                      + DATA_SETUP_BEFORE_WRITE_END_NS
                                      + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_CYC = (PULSE_A > PULSE_B) ? PULSE_A : PULSE_B;
  localparam int unsigned TURN_CYC  = (OUTPUT_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter width and values.
  localparam int unsigned CNT_W = 3;
  localparam logic [CNT_W-1:0] READ_CNT  = CNT_W'(READ_CYC);
  localparam logic [CNT_W-1:0] WRITE_CNT = CNT_W'(WRITE_CYC);
  localparam logic [CNT_W-1:0] TURN_CNT  = CNT_W'(TURN_CYC);

  // Reset levels of the control pins.
  localparam logic RST_SEL_N    = 1'b1;
  localparam logic RST_SEL_HI   = 1'b0;
  localparam logic RST_STROBE_N = 1'b1;

  // Request from the user side.
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0]  lane_en;
  } asb_req_s;

  // Control pins to the memory.
  typedef struct packed {
    logic              select_low_active;
    logic              select_high_active;
    logic              write_strobe_n;
    logic              output_enable_n;
    logic              upper_lane_enable_n;
    logic              lower_lane_enable_n;
    logic [ADDR_W-1:0] addr;
  } asb_pins_s;

  // Controller states.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10,
    ST_TURN  = 2'b11
  } asb_state_e;

endpackage

// ===== src/asb_lane_io.sv
// Data pin drivers per byte lane, with write data and read capture flops.
module asb_lane_io (
  // Clock and reset.
  input  wire logic                       clk_in,
  input  wire logic                       arst_n_in,
  // Control from the sequencer.
  input  wire logic                       load_in,
  input  wire logic                       drive_in,
  input  wire logic                       capture_in,
  input  wire logic [asb_pkg::LANES-1:0]  lane_en_in,
  input  wire logic [asb_pkg::DATA_W-1:0] wdata_in,
  // Data pins.
  input  wire logic [asb_pkg::DATA_W-1:0] dq_in,
  output logic      [asb_pkg::DATA_W-1:0] dq_out,
  output logic      [asb_pkg::DATA_W-1:0] dq_oe_out,
  // Captured read data.
  output logic      [asb_pkg::DATA_W-1:0] rdata_out
);

  genvar g;
  generate
    for (g = 0; g < asb_pkg::LANES; g++)
    begin : g_lane
      logic [asb_pkg::LANE_W-1:0] wd_reg;
      logic                       oe_reg;
      logic [asb_pkg::LANE_W-1:0] rd_reg;

      // Write data is held steady through the whole write and until the next write is taken.
      always_ff @(posedge clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
          wd_reg <= 8'h00;
        else if (load_in)
          wd_reg <= wdata_in[g*asb_pkg::LANE_W +: asb_pkg::LANE_W];
      end

      // The lane is driven only during a write to an enabled lane.
      always_ff @(posedge clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
          oe_reg <= 1'b0;
        else
          oe_reg <= drive_in & lane_en_in[g];
      end

      // Read data of an enabled lane is captured at the end of the read.
      always_ff @(posedge clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
          rd_reg <= 8'h00;
        else if (capture_in && lane_en_in[g])
          rd_reg <= dq_in[g*asb_pkg::LANE_W +: asb_pkg::LANE_W];
      end

      // Lane outputs.
      assign dq_out[g*asb_pkg::LANE_W +: asb_pkg::LANE_W]    = wd_reg;
      assign dq_oe_out[g*asb_pkg::LANE_W +: asb_pkg::LANE_W] = {asb_pkg::LANE_W{oe_reg}};
      assign rdata_out[g*asb_pkg::LANE_W +: asb_pkg::LANE_W] = rd_reg;
    end
  endgenerate

endmodule

// ===== src/asb_host.sv
// Host controller that runs read and write cycles on an asynchronous 16-bit static memory.
// How it works
// - Write spans overlap of all active signals
// - Data held until strobe ends write
// - Host never drives while memory drives
// - Strobe write long enough for turnoff plus setup
// - Strobe stays high through every read
// - Address changes at the same edge the selects assert
// - Selects and lanes always at firm levels
module asb_host (
  // Clock and reset.
  input  wire logic                       clk_in,
  input  wire logic                       arst_n_in,
  // User request.
  input  wire logic                       req_valid_in,
  input  wire asb_pkg::asb_req_s          req_in,
  output logic                            req_ready_out,
  // User answer.
  output logic                            done_out,
  output logic      [asb_pkg::DATA_W-1:0] rdata_out,
  // Memory control pins.
  output asb_pkg::asb_pins_s              pins_out,
  // Memory data pins.
  input  wire logic [asb_pkg::DATA_W-1:0] dq_in,
  output logic      [asb_pkg::DATA_W-1:0] dq_out,
  output logic      [asb_pkg::DATA_W-1:0] dq_oe_out
);

  asb_pkg::asb_state_e          state_reg;
  asb_pkg::asb_state_e          state_next;
  logic [asb_pkg::CNT_W-1:0]    cnt_reg;
  logic [asb_pkg::CNT_W-1:0]    cnt_next;
  logic [asb_pkg::ADDR_W-1:0]   addr_reg;
  logic [asb_pkg::LANES-1:0]    lane_reg;
  logic                         sel_reg;
  logic                         strobe_reg;
  logic                         oe_n_reg;
  logic                         done_reg;
  logic                         take;
  logic                         last;

  // A request is taken only while idle and with a lane enabled.
  assign req_ready_out = (state_reg == asb_pkg::ST_IDLE);
  assign take          = req_ready_out && req_valid_in && (req_in.lane_en != 2'h0);
  assign last          = (cnt_reg == 3'h1);

  // Next state and counter.
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      asb_pkg::ST_IDLE:
      begin
        if (take && req_in.write)
        begin
          state_next = asb_pkg::ST_WRITE;
          cnt_next   = asb_pkg::WRITE_CNT;
        end
        else if (take)
        begin
          state_next = asb_pkg::ST_READ;
          cnt_next   = asb_pkg::READ_CNT;
        end
      end
      asb_pkg::ST_READ:
      begin
        cnt_next = cnt_reg - 3'h1;
        if (last)
        begin
          state_next = asb_pkg::ST_TURN;
          cnt_next   = asb_pkg::TURN_CNT;
        end
      end
      asb_pkg::ST_WRITE:
      begin
        cnt_next = cnt_reg - 3'h1;
        if (last)
          state_next = asb_pkg::ST_IDLE;
      end
      asb_pkg::ST_TURN:
      begin
        cnt_next = cnt_reg - 3'h1;
        if (last)
          state_next = asb_pkg::ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_reg <= asb_pkg::ST_IDLE;
      cnt_reg   <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Address and lanes are latched at the same edge the selects assert.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      addr_reg <= 19'h00000;
      lane_reg <= 2'h0;
    end
    else if (take)
    begin
      addr_reg <= req_in.addr;
      lane_reg <= req_in.lane_en;
    end
  end

  // Select is asserted for the read or write cycle and dropped otherwise.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      sel_reg <= 1'b0;
    else
      sel_reg <= (state_next == asb_pkg::ST_READ) || (state_next == asb_pkg::ST_WRITE);
  end

  // Strobe is low only in a write; it rises with the select so the write ends together.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      strobe_reg <= asb_pkg::RST_STROBE_N;
    else
      strobe_reg <= !(state_next == asb_pkg::ST_WRITE);
  end

  // Output enable is low only for a read, so writes run with memory outputs off.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      oe_n_reg <= 1'b1;
    else
      oe_n_reg <= !(state_next == asb_pkg::ST_READ);
  end

  // Completion pulse, one cycle after the last cycle of a transfer.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      done_reg <= 1'b0;
    else
      done_reg <= last && ((state_reg == asb_pkg::ST_READ) || (state_reg == asb_pkg::ST_WRITE));
  end

  // Pin drive; every control pin always has a firm level.
  always_comb
  begin
    pins_out                     = '0;
    pins_out.select_low_active   = sel_reg ? 1'b0 : asb_pkg::RST_SEL_N;
    pins_out.select_high_active  = sel_reg ? 1'b1 : asb_pkg::RST_SEL_HI;
    pins_out.write_strobe_n      = strobe_reg;
    pins_out.output_enable_n     = oe_n_reg;
    pins_out.upper_lane_enable_n = !(sel_reg && lane_reg[1]);
    pins_out.lower_lane_enable_n = !(sel_reg && lane_reg[0]);
    pins_out.addr                = addr_reg;
  end

  assign done_out = done_reg;

  // Data lanes; drive ends at the same edge the strobe rises, with no hold after it.
  asb_lane_io u_lane (
    .clk_in     (clk_in),
    .arst_n_in  (arst_n_in),
    .load_in    (take && req_in.write),
    .drive_in   (state_next == asb_pkg::ST_WRITE),
    .capture_in ((state_reg == asb_pkg::ST_READ) && last),
    .lane_en_in (take ? req_in.lane_en : lane_reg),
    .wdata_in   (req_in.wdata),
    .dq_in      (dq_in),
    .dq_out     (dq_out),
    .dq_oe_out  (dq_oe_out),
    .rdata_out  (rdata_out)
  );

endmodule

// ===== verification/asb_host_monitor.sv
// Checker of the pin protocol driven by the static memory host.
module asb_host_monitor (
  // Watched ports.
  input wire logic                       clk_in,
  input wire logic                       arst_n_in,
  input wire logic                       req_valid_in,
  input wire asb_pkg::asb_req_s          req_in,
  input wire logic                       req_ready_out,
  input wire logic                       done_out,
  input wire logic [asb_pkg::DATA_W-1:0] rdata_out,
  input wire asb_pkg::asb_pins_s         pins_out,
  input wire logic [asb_pkg::DATA_W-1:0] dq_in,
  input wire logic [asb_pkg::DATA_W-1:0] dq_out,
  input wire logic [asb_pkg::DATA_W-1:0] dq_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire        sel  = !pins_out.select_low_active && pins_out.select_high_active;
  wire        we_n = pins_out.write_strobe_n;
  wire        oe_n = pins_out.output_enable_n;
  wire [15:0] mask = {{8{!pins_out.upper_lane_enable_n}}, {8{!pins_out.lower_lane_enable_n}}};
  wire [1:0]  ln_n = {pins_out.upper_lane_enable_n, pins_out.lower_lane_enable_n};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // A request accepted by the host, and the strobe pulse of a write.
  sequence take_s;
    req_ready_out && req_valid_in && req_in.lane_en != 2'h0;
  endsequence
  sequence pulse_s;
    !we_n [*3] ##1 we_n;
  endsequence
  read_start_a: assert property (take_s ##0 !req_in.write |=> sel && !oe_n && we_n
    && ln_n == ~$past(req_in.lane_en)) else $error("read start pins wrong");
  write_start_a: assert property (take_s ##0 req_in.write |=> sel && !we_n && oe_n
    && ln_n == ~$past(req_in.lane_en) && (dq_out & mask) == ($past(req_in.wdata) & mask))
    else $error("write start pins wrong");
  write_len_a: assert property ($fell(we_n) |-> pulse_s)
    else $error("strobe length wrong");
  write_end_a: assert property ($rose(we_n) |-> !sel && dq_oe_out == 16'h0)
    else $error("write end not together");
  lane_drive_a: assert property (!we_n |-> dq_oe_out == mask)
    else $error("data drive lanes wrong");
  no_clash_a: assert property (dq_oe_out != 16'h0 |-> oe_n)
    else $error("drive while memory out");
  read_strobe_a: assert property (!oe_n |-> we_n) else $error("strobe low in read");
  addr_hold_a: assert property (sel && $past(sel) |-> $stable(pins_out.addr))
    else $error("address moved");
  done_time_a: assert property (take_s |-> ##4 done_out) else $error("done late");
  zero_lane_a: assert property (req_ready_out && req_valid_in && req_in.lane_en == 2'h0
    |=> req_ready_out && !sel) else $error("empty lane request taken");
  turn_gap_a: assert property ($rose(oe_n) |-> !sel && !req_ready_out ##1 req_ready_out)
    else $error("turnaround wrong");
endmodule

// ===== verification/asb_sram_model.sv
// Behavioural model of the asynchronous 16-bit static memory.
module asb_sram_model (
  // Clock used only to sample the open write window.
  input wire logic                       clk_in,
  // Pins from the host.
  input wire asb_pkg::asb_pins_s         pins_in,
  input wire logic [asb_pkg::DATA_W-1:0] dq_in,
  // Data pins driven by the memory.
  output logic     [asb_pkg::DATA_W-1:0] dq_out,
  output logic     [asb_pkg::DATA_W-1:0] dq_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int unsigned]; // Words by 19-bit address.
  logic        sel;
  logic        rd;
  logic [15:0] w;
  // Select decode and per-lane read drive; unwritten words read 16'hc3c3 XOR the low address bits.
  always @*
  begin
    sel = !pins_in.select_low_active && pins_in.select_high_active;
    rd = sel && pins_in.write_strobe_n && !pins_in.output_enable_n;
    dq_oe_out = {{8{rd && !pins_in.upper_lane_enable_n}},
                 {8{rd && !pins_in.lower_lane_enable_n}}};
    dq_out = mem.exists(pins_in.addr) ? mem[pins_in.addr]
                                      : 16'hc3c3 ^ pins_in.addr[15:0];
  end
  // Stores the enabled lanes while select, strobe and a lane are all active.
  always @(negedge clk_in)
  begin
    w = dq_out;
    if (!pins_in.lower_lane_enable_n) w[7:0] = dq_in[7:0];
    if (!pins_in.upper_lane_enable_n) w[15:8] = dq_in[15:8];
    if (sel && !pins_in.write_strobe_n && w != dq_out) mem[pins_in.addr] = w;
  end
endmodule

// ===== verification/tb.sv
// Self-checking testbench of the static memory host.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_in = 1'b0;
  logic               arst_n_in = 1'b0;
  logic               req_valid = 1'b0;
  asb_pkg::asb_req_s  req = '0;
  asb_pkg::asb_pins_s pins;
  logic               req_ready, done;
  logic [15:0]        rdata, dq_out, dq_oe, mem_dq, mem_oe, dq_wire;
  logic [15:0]        float_pat = 16'h5a5a;
  logic [15:0]        exp_rd = 16'h0;
  int                 failures = 0;
  int                 samples_checked = 0;
  always #10 clk_in = ~clk_in;
  // Released data lines show a pattern that changes every cycle.
  always @(posedge clk_in) float_pat <= ~float_pat;
  assign dq_wire = (dq_oe & dq_out) | (~dq_oe & mem_oe & mem_dq) | (~dq_oe & ~mem_oe & float_pat);
  asb_host asb_host_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_valid_in(req_valid),
    .req_in(req), .req_ready_out(req_ready), .done_out(done), .rdata_out(rdata),
    .pins_out(pins), .dq_in(dq_wire), .dq_out(dq_out), .dq_oe_out(dq_oe));
  asb_sram_model asb_sram_model_inst (.clk_in(clk_in), .pins_in(pins), .dq_in(dq_wire),
    .dq_out(mem_dq), .dq_oe_out(mem_oe));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      failures++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic xfer(input logic w, input logic [18:0] a, input logic [15:0] d,
                      input logic [1:0] l);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= '{write: w, addr: a, wdata: d, lane_en: l};
    do @(posedge clk_in); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    while (done !== 1'b1 && n < 10)
    begin
      @(posedge clk_in);
      n++;
    end
    check({15'h0, done}, 16'h1);
  endtask
  // Reads a word; lanes left out keep their previous captured value.
  task automatic rd(input logic [18:0] a, input logic [1:0] l, input logic [15:0] want);
    xfer(1'b0, a, 16'h0, l);
    exp_rd = {l[1] ? want[15:8] : exp_rd[15:8], l[0] ? want[7:0] : exp_rd[7:0]};
    check(rdata, exp_rd);
  endtask
  // Writes and reads back per lane, back to back, at a low address and at the top of the address range.
  task automatic t_lanes();
    xfer(1'b1, 19'h5, 16'h1234, 2'h3);
    rd(19'h5, 2'h3, 16'h1234);
    xfer(1'b1, 19'h5, 16'habcd, 2'h2);
    rd(19'h5, 2'h3, 16'hab34);
    xfer(1'b1, 19'h5, 16'h9876, 2'h1);
    xfer(1'b1, 19'h7ffff, 16'h0f0f, 2'h3);
    rd(19'h7ffff, 2'h1, 16'h0f0f);
    rd(19'h7ffff, 2'h2, 16'h0f0f);
    rd(19'h5, 2'h3, 16'hab76);
  endtask
  // A request with no lane enabled is not taken and writes nothing.
  task automatic t_zero();
    req_valid <= 1'b1;
    req <= '{write: 1'b1, addr: 19'h3, wdata: 16'hffff, lane_en: 2'h0};
    repeat (6)
    begin
      @(posedge clk_in);
      check({14'h0, req_ready, done}, 16'h2);
    end
    rd(19'h3, 2'h3, 16'hc3c0);
  endtask
  // Reset in the middle of a write deselects the memory and frees the data lines.
  task automatic t_reset();
    req_valid <= 1'b1;
    req <= '{write: 1'b1, addr: 19'h9, wdata: 16'h5555, lane_en: 2'h3};
    @(posedge clk_in);
    req_valid <= 1'b0;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({14'h0, pins.select_low_active, pins.write_strobe_n}, 16'h3);
    check(dq_oe, 16'h0);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    xfer(1'b1, 19'h9, 16'h8421, 2'h3);
    rd(19'h9, 2'h3, 16'h8421);
  endtask
  task automatic finish_test();
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    t_lanes();
    t_zero();
    t_reset();
    finish_test();
  end
  // Watchdog at 5000 cycles, well beyond the hundred or so cycles the tests need.
  initial
  begin
    #100000;
    failures++;
    finish_test();
  end
endmodule
bind asb_host asb_host_monitor asb_host_monitor_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
  .done_out(done_out), .rdata_out(rdata_out), .pins_out(pins_out), .dq_in(dq_in),
  .dq_out(dq_out), .dq_oe_out(dq_oe_out));
